// ===== iets_defines.svh
// Constants of the interrupt, event transfer and trap system.
// Assumes inclusion by bare name from the package and the design files.
`ifndef IETS_DEFINES_SVH
`define IETS_DEFINES_SVH
`define IETS_NODES 96
`define IETS_NODE_W 7
`define IETS_CHANS 8
`define IETS_CH_W 3
`define IETS_CH_LSB 2
`define IETS_TRAPS 8
`define IETS_ERU 4
`define IETS_ESR 3
`define IETS_SHARED 8
`define IETS_SHARED_BASE 7'h58
`define IETS_LVL_W 4
`define IETS_AW 8
`define IETS_DW 16
`define IETS_PTR_W 16
`define IETS_CNT_W 8
`define IETS_VEC_W 7
`define IETS_VEC_NODE_BASE 7'h08
`define IETS_LAT_CACHE 4'h7
`define IETS_LAT_NOCACHE 4'hb
`define IETS_LAT_ADJ 4'h2
`define IETS_A_CHAN 8'h60
`define IETS_A_TRAP 8'h80
`define IETS_A_SEL 8'h81
`define IETS_A_EDGE 8'h82
`define IETS_A_GATE 8'h86
`define IETS_A_ESR 8'h8a
`define IETS_A_STAT 8'h8b
`define IETS_F_CTL 2'h0
`define IETS_F_SRC 2'h1
`define IETS_F_DST 2'h2
`define IETS_F_CNT 2'h3
`define IETS_STEP_BYTE 16'h0001
`define IETS_STEP_WORD 16'h0002
`define IETS_TRAP_SR0 0
`define IETS_TRAP_SR1 1
`define IETS_GM_OFF 2'h0
`define IETS_GM_ALWAYS 2'h1
`define IETS_GM_MATCH 2'h2
`define IETS_GM_MISS 2'h3
`endif

// ===== iets_pkg.sv
// Types shared by the interrupt system top and its router stages.
// Assumes the defines header is on the include path.
`include "iets_defines.svh"
package iets_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_LAT = 2'b01} iets_st_t;
  typedef struct packed {
    logic [`IETS_CH_W-1:0] ch;
    logic event_transfer_channel;
    logic flag;
    logic en;
    logic [`IETS_LVL_W-1:0] lvl;
  } iets_node_t;
  typedef struct packed {
    logic word;
    logic inc_src;
    logic inc_dst;
    logic cont;
  } iets_cctl_t;
  typedef struct packed {
    iets_cctl_t ctl;
    logic [`IETS_PTR_W-1:0] src;
    logic [`IETS_PTR_W-1:0] dst;
    logic [`IETS_CNT_W-1:0] cnt;
  } iets_chan_t;
  typedef struct packed {
    logic valid;
    logic word;
    logic [`IETS_CH_W-1:0] ch;
    logic [`IETS_PTR_W-1:0] src;
    logic [`IETS_PTR_W-1:0] dst;
  } iets_move_t;
  typedef struct packed {
    logic fall;
    logic rise;
  } iets_edge_cfg_t;
  typedef struct packed {
    logic [1:0] mode;
    logic [`IETS_ERU-1:0] mask;
    logic [1:0] sel;
  } iets_gate_cfg_t;
  typedef struct packed {
    logic prev;
    logic evt;
  } iets_edge_st_t;
  typedef struct packed {
    logic out;
  } iets_gate_st_t;
  typedef struct packed {
    iets_node_t [`IETS_NODES-1:0] node;
    iets_chan_t [`IETS_CHANS-1:0] chan;
    logic [`IETS_SHARED-1:0] sel;
    iets_edge_cfg_t [`IETS_ERU-1:0] edge_cfg;
    iets_gate_cfg_t [`IETS_ERU-1:0] gate_cfg;
    logic [`IETS_ESR-1:0] esr_en;
    logic [`IETS_ESR-1:0] esr_prev;
    logic [`IETS_TRAPS-1:0] trap_flag;
    logic [`IETS_TRAPS-1:0] trap_pend;
    logic trap_busy;
    logic [`IETS_CH_W-1:0] trap_cur;
    iets_st_t st;
    logic [`IETS_LVL_W-1:0] lat;
    logic [`IETS_NODE_W-1:0] win;
    logic [`IETS_DW-1:0] rdata;
    logic int_start;
    logic trap_start;
    logic [`IETS_VEC_W-1:0] vector;
    logic steal;
    iets_move_t move;
  } iets_state_t;
endpackage

// ===== iets_edge_event_stage.sv
// Edge event stage: one router input channel with edge selection.
// Assumes the input is synchronous to the clock and reset is synchronised.
`timescale 1ns/1ps
module iets_edge_event_stage (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_in,
  input iets_pkg::iets_edge_cfg_t i_cfg,
  output logic o_evt
);
  import iets_pkg::*;
  iets_edge_st_t state_reg;
  iets_edge_st_t state_next;

  // Detect the selected edges; the event is a one-cycle pulse
  always_comb begin
    state_next = state_reg;
    state_next.prev = i_in;
    state_next.evt = (i_cfg.rise & i_in & ~state_reg.prev) |
                     (i_cfg.fall & ~i_in & state_reg.prev);
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_evt = state_reg.evt;

  a_rise_event: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_cfg.rise && i_in && !state_reg.prev) |=> o_evt)
    else $error("rising edge gave no event");
endmodule

// ===== iets_output_gating_stage.sv
// Output gating stage: picks one routed event and filters it on a pattern.
// Assumes events come from the edge stages of the same clock domain.
`timescale 1ns/1ps
`include "iets_defines.svh"
module iets_output_gating_stage (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [`IETS_ERU-1:0] i_evt,
  input wire logic [`IETS_ERU-1:0] i_lvl,
  input iets_pkg::iets_gate_cfg_t i_cfg,
  output logic o_out
);
  import iets_pkg::*;
  iets_gate_st_t state_reg;
  iets_gate_st_t state_next;
  logic hit;

  // Routing matrix picks one event; the pattern compares the input levels
  always_comb begin
    hit = ((i_lvl & i_cfg.mask) == i_cfg.mask);
    state_next = state_reg;
    case (i_cfg.mode)
      `IETS_GM_ALWAYS: state_next.out = i_evt[i_cfg.sel];
      `IETS_GM_MATCH: state_next.out = i_evt[i_cfg.sel] & hit;
      `IETS_GM_MISS: state_next.out = i_evt[i_cfg.sel] & ~hit;
      default: state_next.out = 1'b0;
    endcase
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_out = state_reg.out;

  a_gate_pass_always: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_cfg.mode == `IETS_GM_ALWAYS && i_evt[i_cfg.sel]) |=> o_out)
    else $error("ungated event was dropped");
endmodule

// ===== iets_top.sv
// Interrupt, event transfer and trap system for a 16-bit controller core.
// Assumes synchronous request pulses, a core that takes vectors and
// performs the one-cycle moves, and a plain register port.
// Function
// - Each node chooses vectored interrupt or event transfer channel service.
// - Vectored service branches to a vector; a transfer steals one cycle only.
// - A transfer moves byte or word, then bumps source and/or destination pointer.
// - Each service decrements the channel counter, except in continuous mode.
// - Counter reaching zero raises a vectored interrupt of the originating node.
// - Eight independent transfer channels are provided.
// - Interrupt response takes 7 clocks with jump cache, 11 without.
// - 96 nodes, each with request flag, enable flag and priority field.
// - Shared nodes take their source from programmable source selection bits.
// - Four router inputs detect rising, falling or both edges.
// - Routed events pass four gating stages filtering on pattern match or miss.
// - A hardware trap branches at once and sets its trap flag bit.
// - A trap preempts anything except a trap of higher or equal priority in service.
// - Vectored and transfer requests do not preempt a running trap.
// - Three service request pins raise the two system request traps.
// - A software trap number invokes the matching interrupt or trap service.
// - Writing a node's request flag requests service like hardware.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "iets_defines.svh"
module iets_top (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [`IETS_AW-1:0] i_addr,
  input wire logic [`IETS_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`IETS_DW-1:0] o_rdata,
  input wire logic [`IETS_NODES-1:0] i_src_req,
  input wire logic [`IETS_SHARED-1:0] i_alt_req,
  input wire logic [`IETS_ERU-1:0] i_eru_in,
  input wire logic [`IETS_ESR-1:0] i_esr_pin,
  input wire logic [`IETS_TRAPS-1:0] i_hw_trap,
  input wire logic i_swtrap_valid,
  input wire logic [`IETS_VEC_W-1:0] i_swtrap_num,
  input wire logic [`IETS_LVL_W-1:0] i_cpu_level,
  input wire logic i_jump_cache,
  input wire logic i_svc_done,
  output logic o_int_start,
  output logic o_trap_start,
  output logic [`IETS_VEC_W-1:0] o_vector,
  output logic o_trap_busy,
  output logic o_steal,
  output iets_pkg::iets_move_t o_move
);
  import iets_pkg::*;

  logic [1:0] rst_sync;
  logic rst_n;
  iets_state_t state_reg;
  iets_state_t state_next;
  logic [`IETS_ERU-1:0] eru_evt;
  logic [`IETS_ERU-1:0] gate_out;
  logic [`IETS_NODES-1:0] node_set;
  logic [`IETS_TRAPS-1:0] trap_set;
  logic [`IETS_ESR-1:0] esr_rise;
  logic found;
  logic [`IETS_NODE_W-1:0] best;
  logic [`IETS_LVL_W-1:0] best_lvl;
  logic tfound;
  logic [`IETS_CH_W-1:0] twin;
  iets_node_t wr_node;

  // Pointer step for one transfer; a word moves two byte addresses
  function automatic logic [`IETS_PTR_W-1:0] iets_step(input logic [`IETS_PTR_W-1:0] p,
                                                       input logic inc, input logic word);
    iets_step = !inc ? p : p + (word ? `IETS_STEP_WORD : `IETS_STEP_BYTE);
  endfunction

  // Channel register window decode
  function automatic logic iets_is_chan(input logic [`IETS_AW-1:0] a);
    iets_is_chan = (a >= `IETS_A_CHAN) && (a < `IETS_A_TRAP);
  endfunction

  // Reset release through two flops so every flop leaves reset together
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Node image of the write data, shared by the write path and its check
  assign wr_node = iets_node_t'(i_wdata[$bits(iets_node_t)-1:0]);

  // External request router: edge stages, then gating stages
  for (genvar g = 0; g < `IETS_ERU; g++) begin : g_eru
    iets_edge_event_stage u_edge (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(rst_n),
      .i_in(i_eru_in[g]),
      .i_cfg(state_reg.edge_cfg[g]),
      .o_evt(eru_evt[g])
    );
    iets_output_gating_stage u_gate (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(rst_n),
      .i_evt(eru_evt),
      .i_lvl(i_eru_in),
      .i_cfg(state_reg.gate_cfg[g]),
      .o_out(gate_out[g])
    );
  end

  // Request sources per node, shared nodes picked by the select bits
  always_comb begin
    node_set = '0;
    trap_set = i_hw_trap;
    esr_rise = i_esr_pin & ~state_reg.esr_prev & state_reg.esr_en;
    for (int i = 0; i < `IETS_NODES; i++) begin
      if (i >= int'(`IETS_SHARED_BASE) && state_reg.sel[i - int'(`IETS_SHARED_BASE)]) begin
        node_set[i] = i_alt_req[i - int'(`IETS_SHARED_BASE)];
      end else begin
        node_set[i] = i_src_req[i];
      end
    end
    node_set[`IETS_ERU-1:0] = node_set[`IETS_ERU-1:0] | gate_out;
    // Pin 0 asks for the first system request, pins 1 and 2 for the second
    trap_set[`IETS_TRAP_SR0] = trap_set[`IETS_TRAP_SR0] | esr_rise[0];
    trap_set[`IETS_TRAP_SR1] = trap_set[`IETS_TRAP_SR1] | (|esr_rise[`IETS_ESR-1:1]);
    if (i_swtrap_valid) begin
      if (i_swtrap_num < `IETS_VEC_W'(`IETS_TRAPS)) begin
        trap_set[i_swtrap_num[`IETS_CH_W-1:0]] = 1'b1;
      end else if (i_swtrap_num - `IETS_VEC_NODE_BASE < `IETS_VEC_W'(`IETS_NODES)) begin
        node_set[i_swtrap_num - `IETS_VEC_NODE_BASE] = 1'b1;
      end
    end
  end

  // Priority search; ties go to the lowest node number
  always_comb begin
    found = 1'b0;
    best = '0;
    best_lvl = '0;
    for (int i = 0; i < `IETS_NODES; i++) begin
      if (state_reg.node[i].flag && state_reg.node[i].en &&
          (!found || state_reg.node[i].lvl > best_lvl)) begin
        found = 1'b1;
        best = `IETS_NODE_W'(i);
        best_lvl = state_reg.node[i].lvl;
      end
    end
    tfound = 1'b0;
    twin = '0;
    for (int t = `IETS_TRAPS - 1; t >= 0; t--) begin
      if (state_reg.trap_pend[t]) begin
        tfound = 1'b1;
        twin = `IETS_CH_W'(t);
      end
    end
  end

  // Next state: register port, traps, service sequencing, then sets
  always_comb begin
    state_next = state_reg;
    state_next.int_start = 1'b0;
    state_next.trap_start = 1'b0;
    state_next.steal = 1'b0;
    state_next.move.valid = 1'b0;
    state_next.rdata = '0;
    state_next.esr_prev = i_esr_pin;
    // Register writes; a node write stores the flag as given
    if (i_wr) begin
      if (i_addr < `IETS_AW'(`IETS_NODES)) begin
        state_next.node[i_addr[`IETS_NODE_W-1:0]] = wr_node;
      end else if (iets_is_chan(i_addr)) begin
        case (i_addr[`IETS_CH_LSB-1:0])
          `IETS_F_CTL: state_next.chan[i_addr[`IETS_CH_LSB +: `IETS_CH_W]].ctl =
            iets_cctl_t'(i_wdata[$bits(iets_cctl_t)-1:0]);
          `IETS_F_SRC: state_next.chan[i_addr[`IETS_CH_LSB +: `IETS_CH_W]].src = i_wdata;
          `IETS_F_DST: state_next.chan[i_addr[`IETS_CH_LSB +: `IETS_CH_W]].dst = i_wdata;
          default: state_next.chan[i_addr[`IETS_CH_LSB +: `IETS_CH_W]].cnt =
            i_wdata[`IETS_CNT_W-1:0];
        endcase
      end else begin
        // Trap flags clear by writing ones, so a stray write cannot set one
        if (i_addr == `IETS_A_TRAP) begin
          state_next.trap_flag = state_reg.trap_flag & ~i_wdata[`IETS_TRAPS-1:0];
        end
        if (i_addr == `IETS_A_SEL) begin
          state_next.sel = i_wdata[`IETS_SHARED-1:0];
        end
        if (i_addr == `IETS_A_ESR) begin
          state_next.esr_en = i_wdata[`IETS_ESR-1:0];
        end
        for (int k = 0; k < `IETS_ERU; k++) begin
          if (i_addr == `IETS_A_EDGE + `IETS_AW'(k)) begin
            state_next.edge_cfg[k] = iets_edge_cfg_t'(i_wdata[$bits(iets_edge_cfg_t)-1:0]);
          end
          if (i_addr == `IETS_A_GATE + `IETS_AW'(k)) begin
            state_next.gate_cfg[k] = iets_gate_cfg_t'(i_wdata[$bits(iets_gate_cfg_t)-1:0]);
          end
        end
      end
    end
    // Register reads; unmapped addresses answer zero
    if (i_rd) begin
      if (i_addr < `IETS_AW'(`IETS_NODES)) begin
        state_next.rdata = `IETS_DW'(state_reg.node[i_addr[`IETS_NODE_W-1:0]]);
      end else if (iets_is_chan(i_addr)) begin
        case (i_addr[`IETS_CH_LSB-1:0])
          `IETS_F_CTL: state_next.rdata =
            `IETS_DW'(state_reg.chan[i_addr[`IETS_CH_LSB +: `IETS_CH_W]].ctl);
          `IETS_F_SRC: state_next.rdata = state_reg.chan[i_addr[`IETS_CH_LSB +: `IETS_CH_W]].src;
          `IETS_F_DST: state_next.rdata = state_reg.chan[i_addr[`IETS_CH_LSB +: `IETS_CH_W]].dst;
          default: state_next.rdata =
            `IETS_DW'(state_reg.chan[i_addr[`IETS_CH_LSB +: `IETS_CH_W]].cnt);
        endcase
      end else begin
        if (i_addr == `IETS_A_TRAP) begin
          state_next.rdata = `IETS_DW'(state_reg.trap_flag);
        end
        if (i_addr == `IETS_A_SEL) begin
          state_next.rdata = `IETS_DW'(state_reg.sel);
        end
        if (i_addr == `IETS_A_ESR) begin
          state_next.rdata = `IETS_DW'(state_reg.esr_en);
        end
        if (i_addr == `IETS_A_STAT) begin
          state_next.rdata = `IETS_DW'({state_reg.trap_cur, state_reg.trap_busy, state_reg.st});
        end
        for (int k = 0; k < `IETS_ERU; k++) begin
          if (i_addr == `IETS_A_EDGE + `IETS_AW'(k)) begin
            state_next.rdata = `IETS_DW'(state_reg.edge_cfg[k]);
          end
          if (i_addr == `IETS_A_GATE + `IETS_AW'(k)) begin
            state_next.rdata = `IETS_DW'(state_reg.gate_cfg[k]);
          end
        end
      end
    end
    // Traps: branch at once unless a trap of higher or equal priority is in service
    if (tfound && (!state_reg.trap_busy || twin < state_reg.trap_cur)) begin
      state_next.trap_start = 1'b1;
      state_next.vector = `IETS_VEC_W'(twin);
      state_next.trap_busy = 1'b1;
      state_next.trap_cur = twin;
      state_next.trap_pend[twin] = 1'b0;
      state_next.st = ST_IDLE;
    end else if (state_reg.trap_busy) begin
      // Only one trap level is tracked; return ends the trap service
      if (i_svc_done) begin
        state_next.trap_busy = 1'b0;
      end
    end else begin
      case (state_reg.st)
        ST_IDLE: begin
          if (found && best_lvl > i_cpu_level) begin
            if (state_reg.node[best].event_transfer_channel && (state_reg.chan[state_reg.node[best].ch].ctl.cont ||
                state_reg.chan[state_reg.node[best].ch].cnt != '0)) begin
              // One-cycle transfer instead of a vectored branch
              state_next.steal = 1'b1;
              state_next.win = best;
              state_next.move.valid = 1'b1;
              state_next.move.ch = state_reg.node[best].ch;
              state_next.move.word = state_reg.chan[state_reg.node[best].ch].ctl.word;
              state_next.move.src = state_reg.chan[state_reg.node[best].ch].src;
              state_next.move.dst = state_reg.chan[state_reg.node[best].ch].dst;
              state_next.chan[state_reg.node[best].ch].src =
                iets_step(state_reg.chan[state_reg.node[best].ch].src,
                          state_reg.chan[state_reg.node[best].ch].ctl.inc_src,
                          state_reg.chan[state_reg.node[best].ch].ctl.word);
              state_next.chan[state_reg.node[best].ch].dst =
                iets_step(state_reg.chan[state_reg.node[best].ch].dst,
                          state_reg.chan[state_reg.node[best].ch].ctl.inc_dst,
                          state_reg.chan[state_reg.node[best].ch].ctl.word);
              state_next.node[best].flag = 1'b0;
              if (!state_reg.chan[state_reg.node[best].ch].ctl.cont) begin
                state_next.chan[state_reg.node[best].ch].cnt =
                  state_reg.chan[state_reg.node[best].ch].cnt - `IETS_CNT_W'(1);
                // Last transfer keeps the flag so the node is vectored next
                if (state_reg.chan[state_reg.node[best].ch].cnt == `IETS_CNT_W'(1)) begin
                  state_next.node[best].flag = 1'b1;
                end
              end
            end else begin
              state_next.st = ST_LAT;
              state_next.win = best;
              state_next.lat = (i_jump_cache ? `IETS_LAT_CACHE : `IETS_LAT_NOCACHE) -
                               `IETS_LAT_ADJ;
            end
          end
        end
        ST_LAT: begin
          // The winner is locked for the whole response time
          if (state_reg.lat == '0) begin
            state_next.int_start = 1'b1;
            state_next.vector = `IETS_VEC_W'(state_reg.win) + `IETS_VEC_NODE_BASE;
            state_next.node[state_reg.win].flag = 1'b0;
            state_next.st = ST_IDLE;
          end else begin
            state_next.lat = state_reg.lat - `IETS_LVL_W'(1);
          end
        end
        default: state_next.st = ST_IDLE;
      endcase
    end
    // Hardware and software sets win over any clear in the same cycle
    for (int i = 0; i < `IETS_NODES; i++) begin
      if (node_set[i]) begin
        state_next.node[i].flag = 1'b1;
      end
    end
    state_next.trap_flag = state_next.trap_flag | trap_set;
    state_next.trap_pend = state_next.trap_pend | trap_set;
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata = state_reg.rdata;
  assign o_int_start = state_reg.int_start;
  assign o_trap_start = state_reg.trap_start;
  assign o_vector = state_reg.vector;
  assign o_trap_busy = state_reg.trap_busy;
  assign o_steal = state_reg.steal;
  assign o_move = state_reg.move;

  a_steal_from_idle: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    o_steal |-> (o_move.valid && !o_int_start && $past(state_reg.st) == ST_IDLE))
    else $error("transfer did not come from idle");
  a_latency_cache: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (state_reg.st == ST_IDLE && state_next.st == ST_LAT && i_jump_cache) ##1
    (!state_reg.trap_busy && !o_trap_start)[*7] |-> o_int_start)
    else $error("cached response not seven clocks");
  a_trap_flag_set: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (|i_hw_trap) |=> ((state_reg.trap_flag & $past(i_hw_trap)) == $past(i_hw_trap)))
    else $error("trap flag not set");
  a_trap_preempt: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (o_trap_start && $past(state_reg.trap_busy)) |->
    (o_vector < `IETS_VEC_W'($past(state_reg.trap_cur))))
    else $error("trap preempted a higher trap");
  a_no_int_in_trap: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (o_int_start || o_steal) |-> !$past(state_reg.trap_busy))
    else $error("service started during trap");
  a_sw_flag_write: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (i_wr && i_addr < `IETS_AW'(`IETS_NODES) && state_reg.st == ST_IDLE && !found &&
     wr_node.flag) |=>
    state_reg.node[$past(i_addr[`IETS_NODE_W-1:0])].flag)
    else $error("written request flag lost");
endmodule

// ===== iets_core_model.sv
// Core model: returns from trap service a fixed time after the latest trap branch.
// Assumes trap starts and stolen cycles are one-cycle pulses.
`timescale 1ns/1ps
module iets_core_model #(
  parameter int SVC_WAIT = 30
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_trap_start,
  input wire logic i_steal,
  output logic o_svc_done,
  output int o_moves
);
  int cnt_reg;
  // A nested trap restarts the wait, so only one return is seen
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= 0;
      o_svc_done <= 1'b0;
      o_moves <= 0;
    end else begin
      o_svc_done <= (cnt_reg == 1);
      if (i_trap_start)
        cnt_reg <= SVC_WAIT;
      else if (cnt_reg != 0)
        cnt_reg <= cnt_reg - 1;
      if (i_steal)
        o_moves <= o_moves + 1; // One move per stolen cycle
    end
  end
endmodule

// ===== testbench.sv
// Testbench for the interrupt, event transfer and trap system top.
// Assumes the core model returns from trap services by itself.
`timescale 1ns/1ps
`include "iets_defines.svh"
module testbench;
  import iets_pkg::*;
  logic i_sys_clk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, i_swtrap_valid = 0;
  logic i_jump_cache = 1, i_svc_done, o_int_start, o_trap_start, o_trap_busy, o_steal;
  logic [7:0] i_addr = 0, i_alt_req = 0, i_hw_trap = 0;
  logic [15:0] i_wdata = 0, o_rdata;
  logic [95:0] i_src_req = 0;
  logic [3:0] i_eru_in = 0, i_cpu_level = 0;
  logic [2:0] i_esr_pin = 0;
  logic [6:0] i_swtrap_num = 0, o_vector;
  iets_move_t o_move;
  int fails = 0, n_compared = 0, n1, n0, moves;
  iets_top iets_top_inst (.*);
  iets_core_model iets_core_model_inst (.i_sys_clk, .i_resetn, .i_trap_start(o_trap_start),
    .i_steal(o_steal), .o_svc_done(i_svc_done), .o_moves(moves));
  initial forever #5 i_sys_clk = ~i_sys_clk;
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1;
    @(posedge i_sys_clk);
    i_wr <= 0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1;
    @(posedge i_sys_clk);
    i_rd <= 0;
    #1;
    chk($sformatf("reg %h", a), e, o_rdata);
  endtask
  task pul(input logic [95:0] s, input logic [7:0] a, input logic [7:0] t, input logic sw);
    @(posedge i_sys_clk);
    i_src_req <= s;
    i_alt_req <= a;
    i_hw_trap <= t;
    i_swtrap_valid <= sw;
    @(posedge i_sys_clk);
    i_src_req <= 0;
    i_alt_req <= 0;
    i_hw_trap <= 0;
    i_swtrap_valid <= 0;
  endtask
  // Bounded wait: 0 vectored start, 1 trap start, 2 stolen cycle
  task wait_ev(input int w, output int n);
    for (n = 1; n <= 60; n++) begin
      @(posedge i_sys_clk);
      #1;
      if ((w == 0 && o_int_start === 1'b1) || (w == 1 && o_trap_start === 1'b1) ||
          (w == 2 && o_steal === 1'b1))
        return;
    end
    fails++;
    $display("wrong value wait %0d expected 1 seen 0", w);
    test_done();
  endtask
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_resetn <= 1;
    repeat (4) @(posedge i_sys_clk);
    rd(8'h05, 16'h0000);
    rd(8'h8c, 16'h0000);
    // Software request, then the slower response without the jump cache
    wr(8'h05, 16'h0033);
    wait_ev(0, n1);
    chk("vector", 16'h000d, o_vector);
    @(posedge i_sys_clk);
    i_jump_cache <= 0;
    wr(8'h05, 16'h0033);
    wait_ev(0, n0);
    chk("latency gap", 16'h0004, 16'(n0 - n1));
    rd(8'h05, 16'h0013);
    // Node 2 on channel 1: word moves, source steps, count 2
    wr(8'h02, 16'h00d2);
    wr(8'h64, 16'h000c);
    wr(8'h65, 16'h0100);
    wr(8'h66, 16'h0200);
    wr(8'h67, 16'h0002);
    pul(96'h4, 0, 0, 0);
    wait_ev(2, n1);
    chk("move src", 16'h0100, o_move.src);
    chk("move dst", 16'h0200, o_move.dst);
    chk("move kind", 16'h0019, {o_move.valid, o_move.word, o_move.ch});
    rd(8'h65, 16'h0102);
    rd(8'h67, 16'h0001);
    pul(96'h4, 0, 0, 0);
    wait_ev(2, n1);
    wait_ev(0, n1);
    chk("vector", 16'h000a, o_vector);
    chk("moves", 16'h0002, 16'(moves));
    // Node 4 on channel 2: continuous byte moves, destination steps
    wr(8'h04, 16'h0151);
    wr(8'h68, 16'h0003);
    wr(8'h6a, 16'h0300);
    pul(96'h10, 0, 0, 0);
    wait_ev(2, n1);
    chk("move kind", 16'h0012, {o_move.valid, o_move.word, o_move.ch});
    rd(8'h6a, 16'h0301);
    rd(8'h6b, 16'h0000);
    // Trap 3, preempted by the pin request, blocks a node
    pul(0, 0, 8'h08, 0);
    wait_ev(1, n1);
    chk("trap delay", 16'h0001, 16'(n1));
    chk("trap vector", 16'h0003, o_vector);
    rd(8'h80, 16'h0008);
    wr(8'h8a, 16'h0001);
    @(posedge i_sys_clk);
    i_esr_pin <= 3'h1;
    wait_ev(1, n1);
    chk("pin vector", 16'h0000, o_vector);
    wr(8'h06, 16'h0035);
    wait_ev(0, n1);
    chk("busy at start", 16'h0000, o_trap_busy);
    // Router, software trap number and shared source
    wr(8'h82, 16'h0001);
    wr(8'h86, 16'h0040);
    @(posedge i_sys_clk);
    i_eru_in <= 4'h1;
    repeat (4) @(posedge i_sys_clk);
    rd(8'h00, 16'h0020);
    // Falling edge on input 1, gated on input 0 level: match passes, miss blocks
    wr(8'h83, 16'h0002);
    wr(8'h87, 16'h0085);
    wr(8'h89, 16'h00c5);
    @(posedge i_sys_clk);
    i_eru_in <= 4'h3;
    @(posedge i_sys_clk);
    i_eru_in <= 4'h1;
    repeat (4) @(posedge i_sys_clk);
    rd(8'h01, 16'h0020);
    rd(8'h03, 16'h0000);
    @(posedge i_sys_clk);
    i_swtrap_num <= 7'd20;
    pul(0, 0, 0, 1);
    rd(8'h0c, 16'h0020);
    wr(8'h81, 16'h0001);
    pul(0, 8'h01, 0, 0);
    rd(8'h58, 16'h0020);
    // Pin 1 asks for the second system request trap
    wr(8'h8a, 16'h0003);
    @(posedge i_sys_clk);
    i_esr_pin <= 3'h3;
    wait_ev(1, n1);
    chk("pin1 vector", 16'h0001, o_vector);
    rd(8'h80, 16'h000b);
    test_done();
  end
endmodule
